/* verilog/mie_pkg.sv */
package mie_pkg;

	// Register offsets and layout
	localparam logic [7:0] SENSE_A_OFS     = 8'h37;
	localparam logic [7:0] SENSE_B_OFS     = 8'h3D;
	localparam logic [7:0] SENSE_A_RST     = 8'h00;
	localparam logic [7:0] SENSE_B_RST     = 8'h00;
	localparam logic [7:0] SENSE_A_MASK    = 8'h3F;
	localparam logic [7:0] SENSE_B_MASK    = 8'h0F;
	localparam int         LINE0_POS       = 0;
	localparam int         LINE1_POS       = 2;
	localparam int         LINE2_POS       = 4;
	localparam int         LINE3_POS       = 0;
	localparam int         LINE4_POS       = 2;

	// Sensitivity encodings
	localparam logic [1:0] SENSE_FALL_LOW  = 2'h0;
	localparam logic [1:0] SENSE_RISE      = 2'h1;
	localparam logic [1:0] SENSE_FALL      = 2'h2;
	localparam logic [1:0] SENSE_BOTH      = 2'h3;

	// Source numbering, index 0 is highest priority
	localparam int         NUM_SRC         = 14;
	localparam int         NUM_EXT         = 5;
	localparam int         NUM_PERIPH      = 5;
	localparam int         SRC_AWU         = 0;
	localparam int         SRC_EXT0        = 1;
	localparam int         SRC_EXT1        = 2;
	localparam int         SRC_EXT2        = 3;
	localparam int         SRC_EXT3        = 5;
	localparam int         SRC_EXT4        = 6;
	localparam int         SRC_ATCMP       = 8;
	localparam int         SRC_ATOVF       = 9;
	localparam int         SRC_LTCAP       = 10;
	localparam int         SRC_LTRTC       = 11;

	localparam logic [15:0] VEC_TOP        = 16'hFFFA;
	localparam logic [15:0] VEC_STEP       = 16'h0002;

	typedef enum logic [1:0] {
		MIE_RUN,
		MIE_WAIT,
		MIE_ACTIVE_HALT,
		MIE_HALT
	} mie_pwr_t;

	// Peripheral sources in order awu, atcmp, atovf, ltcap, ltrtc
	typedef struct packed {
		logic [NUM_PERIPH-1:0] set;
		logic [NUM_PERIPH-1:0] enable;
		logic [NUM_PERIPH-1:0] clear;
	} mie_periph_t;

	typedef struct packed {
		logic        valid;
		logic [3:0]  num;
		logic [15:0] vector;
	} mie_req_t;

endpackage : mie_pkg

/* verilog/mie_ext_line.sv */
`timescale 1ns/1ps
module mie_ext_line (
	// Clock and reset
	input  wire logic       sys_clk_i,
	input  wire logic       srst_i,
	// Line and setting
	input  wire logic       line_i,
	input  wire logic [1:0] sense_i,
	input  wire logic       sense_chg_i,
	input  wire logic       ack_i,
	// Result
	output logic            pend_o,
	output logic            fall_o
);
	import mie_pkg::*;

	logic line_r;
	logic pend_r;
	logic pend_nxt;
	logic fall_r;
	logic fall_nxt;

	wire rise_w  = line_i & ~line_r;
	wire fall_w  = ~line_i & line_r;
	wire level_w = (sense_i == SENSE_FALL_LOW);
	wire edge_w  = ((sense_i == SENSE_RISE) & rise_w)
	             | ((sense_i == SENSE_FALL) & fall_w)
	             | ((sense_i == SENSE_BOTH) & (rise_w | fall_w))
	             | (level_w & fall_w);
	wire hit_w   = edge_w | (level_w & ~line_i);

	// Set beats entry clear, setting change discards
	assign pend_nxt = sense_chg_i ? 1'b0
	                : hit_w ? 1'b1
	                : ack_i ? 1'b0 : pend_r;

	// Pending request born of a fall or low level; a rising-edge hit clears it though the request stays pending
	assign fall_nxt = sense_chg_i ? 1'b0
	                : hit_w ? (~line_i & (fall_r | ~pend_r))
	                : ack_i ? 1'b0 : fall_r;

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			line_r <= 1'b1;
			pend_r <= 1'b0;
			fall_r <= 1'b0;
		end else begin
			line_r <= line_i;
			pend_r <= pend_nxt;
			fall_r <= fall_nxt;
		end
	end

	assign pend_o = pend_r;
	assign fall_o = fall_r;
endmodule : mie_ext_line

/* verilog/mie_core.sv */
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
module mie_core (
	// Clock and reset
	input  wire logic                sys_clk_i,
	input  wire logic                srst_i,
	// Register port
	input  wire logic [7:0]          reg_addr_i,
	input  wire logic [7:0]          reg_wdata_i,
	input  wire logic                reg_wr_i,
	input  wire logic                reg_rd_i,
	output logic [7:0]               reg_rdata_o,
	// CPU side
	input  wire logic                irq_mask_i,
	input  wire logic                irq_ack_i,
	input  wire logic [3:0]          irq_ack_num_i,
	input  wire mie_pkg::mie_pwr_t   pwr_mode_i,
	input  wire logic                awu_halt_i,
	output mie_pkg::mie_req_t        irq_req_o,
	output logic                     wake_o,
	// Sources
	input  wire logic [4:0]          ext_line_i,
	input  wire mie_pkg::mie_periph_t periph_i,
	output logic [4:0]               periph_pend_o
);
	import mie_pkg::*;

	logic [7:0]            sense_a_r;
	logic [7:0]            sense_b_r;
	logic [7:0]            sense_a_nxt;
	logic [7:0]            sense_b_nxt;
	logic [7:0]            rdata_r;
	logic [NUM_PERIPH-1:0] per_r;
	logic [NUM_PERIPH-1:0] per_nxt;
	logic [NUM_EXT-1:0]    ext_pend;
	logic [NUM_EXT-1:0]    ext_fall;
	logic [NUM_EXT-1:0]    ext_chg;
	logic [NUM_EXT-1:0]    ext_ack;
	logic [1:0]            sense [NUM_EXT];
	logic [NUM_SRC-1:0]    active;
	logic [NUM_SRC-1:0]    wake_src;
	mie_req_t              req_r;
	mie_req_t              req_nxt;

	function automatic logic [15:0] vec_of(input logic [3:0] n);
		vec_of = VEC_TOP - (VEC_STEP * {12'h000, n});
	endfunction : vec_of

	function automatic logic [3:0] first_set(input logic [NUM_SRC-1:0] v);
		first_set = 4'h0;
		for (int i = NUM_SRC - 1; i >= 0; i--) begin
			if (v[i]) begin
				first_set = 4'(i);
			end
		end
	endfunction : first_set

	// Register decode
	wire wr_a_w   = reg_wr_i & (reg_addr_i == SENSE_A_OFS) & irq_mask_i;
	wire wr_b_w   = reg_wr_i & (reg_addr_i == SENSE_B_OFS) & irq_mask_i;
	assign sense_a_nxt = wr_a_w ? (reg_wdata_i & SENSE_A_MASK) : sense_a_r;
	assign sense_b_nxt = wr_b_w ? (reg_wdata_i & SENSE_B_MASK) : sense_b_r;
	wire [7:0] rd_mux_w = (reg_addr_i == SENSE_A_OFS) ? sense_a_r
	                    : (reg_addr_i == SENSE_B_OFS) ? sense_b_r : 8'h00;

	assign sense[0] = sense_a_r[LINE0_POS +: 2];
	assign sense[1] = sense_a_r[LINE1_POS +: 2];
	assign sense[2] = sense_a_r[LINE2_POS +: 2];
	assign sense[3] = sense_b_r[LINE3_POS +: 2];
	assign sense[4] = sense_b_r[LINE4_POS +: 2];

	// Setting change per line
	assign ext_chg[0] = wr_a_w & (sense_a_nxt[LINE0_POS +: 2] != sense[0]);
	assign ext_chg[1] = wr_a_w & (sense_a_nxt[LINE1_POS +: 2] != sense[1]);
	assign ext_chg[2] = wr_a_w & (sense_a_nxt[LINE2_POS +: 2] != sense[2]);
	assign ext_chg[3] = wr_b_w & (sense_b_nxt[LINE3_POS +: 2] != sense[3]);
	assign ext_chg[4] = wr_b_w & (sense_b_nxt[LINE4_POS +: 2] != sense[4]);

	wire ack_w = irq_ack_i & req_r.valid;
	assign ext_ack[0] = ack_w & (irq_ack_num_i == 4'(SRC_EXT0));
	assign ext_ack[1] = ack_w & (irq_ack_num_i == 4'(SRC_EXT1));
	assign ext_ack[2] = ack_w & (irq_ack_num_i == 4'(SRC_EXT2));
	assign ext_ack[3] = ack_w & (irq_ack_num_i == 4'(SRC_EXT3));
	assign ext_ack[4] = ack_w & (irq_ack_num_i == 4'(SRC_EXT4));

	for (genvar g = 0; g < NUM_EXT; g++) begin : g_line
		mie_ext_line u_line (
			.sys_clk_i   (sys_clk_i),
			.srst_i      (srst_i),
			.line_i      (ext_line_i[g]),
			.sense_i     (sense[g]),
			.sense_chg_i (ext_chg[g]),
			.ack_i       (ext_ack[g]),
			.pend_o      (ext_pend[g]),
			.fall_o      (ext_fall[g])
		);
	end

	// Peripheral latches: set wins over clear, enable not needed to latch
	assign per_nxt = periph_i.set | (per_r & ~periph_i.clear);

	// Candidate requests, peripheral ones gated by local enable
	always_comb begin
		active = '0;
		active[SRC_AWU]   = per_r[0] & periph_i.enable[0];
		active[SRC_ATCMP] = per_r[1] & periph_i.enable[1];
		active[SRC_ATOVF] = per_r[2] & periph_i.enable[2];
		active[SRC_LTCAP] = per_r[3] & periph_i.enable[3];
		active[SRC_LTRTC] = per_r[4] & periph_i.enable[4];
		active[SRC_EXT0]  = ext_pend[0];
		active[SRC_EXT1]  = ext_pend[1];
		active[SRC_EXT2]  = ext_pend[2];
		active[SRC_EXT3]  = ext_pend[3];
		active[SRC_EXT4]  = ext_pend[4];
	end

	// Which active sources may leave the current low-power mode
	wire ah_w   = (pwr_mode_i == MIE_ACTIVE_HALT);
	wire halt_w = (pwr_mode_i == MIE_HALT);
	wire any_halt_w = ah_w | halt_w;
	always_comb begin
		wake_src = '0;
		wake_src[SRC_AWU]   = halt_w & awu_halt_i;
		wake_src[SRC_EXT0]  = any_halt_w;
		wake_src[SRC_EXT1]  = any_halt_w;
		wake_src[SRC_EXT2]  = any_halt_w & ~ext_fall[2];
		wake_src[SRC_EXT3]  = any_halt_w;
		wake_src[SRC_EXT4]  = ah_w;
		wake_src[SRC_ATCMP] = 1'b0;
		wake_src[SRC_ATOVF] = ah_w;
		wake_src[SRC_LTCAP] = 1'b0;
		wake_src[SRC_LTRTC] = ah_w;
	end

	wire wait_wake_w = (pwr_mode_i == MIE_WAIT) & (|active);
	wire halt_wake_w = |(active & wake_src);

	// Winner selection
	wire [3:0] win_w = first_set(active);
	assign req_nxt.valid  = (|active) & ~irq_mask_i;
	assign req_nxt.num    = win_w;
	assign req_nxt.vector = vec_of(win_w);

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			sense_a_r <= SENSE_A_RST;
			sense_b_r <= SENSE_B_RST;
			per_r     <= '0;
			req_r     <= '0;
			rdata_r   <= 8'h00;
			wake_o    <= 1'b0;
		end else begin
			sense_a_r <= sense_a_nxt;
			sense_b_r <= sense_b_nxt;
			per_r     <= per_nxt;
			req_r     <= req_nxt;
			rdata_r   <= reg_rd_i ? rd_mux_w : 8'h00;
			wake_o    <= wait_wake_w | halt_wake_w;
		end
	end

	assign irq_req_o     = req_r;
	assign reg_rdata_o   = rdata_r;
	assign periph_pend_o = per_r;
endmodule : mie_core

/* testbench/mie_src_model.sv */
`timescale 1ns/1ps
module mie_src_model (
	// Clock
	input  wire logic            sys_clk_i,
	// Commands from the bench
	input  wire logic [4:0]      fire_i,
	input  wire logic [4:0]      en_i,
	input  wire logic [4:0]      clr_i,
	// Toward the block
	output mie_pkg::mie_periph_t periph_o
);
	import mie_pkg::*;
	logic [4:0] set_r;
	logic [4:0] clr_r;
	always_ff @(posedge sys_clk_i) begin
		set_r <= fire_i;
		clr_r <= clr_i;
	end
	assign periph_o = '{set: set_r, enable: en_i, clear: clr_r};
endmodule : mie_src_model

/* testbench/mie_core_sva.sv */
`timescale 1ns/1ps
module mie_core_sva (
	input  wire logic                 sys_clk_i,
	input  wire logic                 srst_i,
	input  wire logic [7:0]           reg_addr_i,
	input  wire logic                 reg_rd_i,
	input  wire logic [7:0]           reg_rdata_o,
	input  wire logic                 irq_mask_i,
	input  wire mie_pkg::mie_periph_t periph_i,
	input  wire logic [4:0]           periph_pend_o,
	input  wire mie_pkg::mie_req_t    irq_req_o
);
	import mie_pkg::*;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (srst_i);
	sequence s_awu_armed;
		periph_i.set[0] ##1 (periph_i.enable[0] && !irq_mask_i && !periph_i.clear[0]);
	endsequence
	chk_rd_a_resv: assert property (reg_rd_i && reg_addr_i == SENSE_A_OFS |=> reg_rdata_o[7:6] == 2'h0) else $error("sense a reserved bits set");
	chk_rd_b_resv: assert property (reg_rd_i && reg_addr_i == SENSE_B_OFS |=> reg_rdata_o[7:4] == 4'h0) else $error("sense b reserved bits set");
	chk_mask_req: assert property (irq_mask_i |=> !irq_req_o.valid) else $error("request while masked");
	chk_vec_map: assert property (irq_req_o.valid |-> irq_req_o.vector == VEC_TOP - {11'h0, irq_req_o.num, 1'b0}) else $error("vector wrong");
	chk_pend_keep: assert property (1'b1 |=> ($past(periph_pend_o & ~periph_i.clear) & ~periph_pend_o) == 5'h0) else $error("pending flag lost");
	chk_set_latch: assert property (1'b1 |=> ($past(periph_i.set) & ~periph_pend_o) == 5'h0) else $error("flag not latched");
	chk_clr_drop: assert property (1'b1 |=> ($past(periph_i.clear & ~periph_i.set) & periph_pend_o) == 5'h0) else $error("flag not cleared");
	chk_awu_req: assert property (s_awu_armed |=> irq_req_o.valid && irq_req_o.num == 4'(SRC_AWU)) else $error("wake-up request missing");
	chk_rtc_src: assert property (irq_req_o.valid && irq_req_o.num == 4'(SRC_LTRTC) |-> $past(periph_pend_o[4] && periph_i.enable[4])) else $error("time-base request unfounded");
endmodule : mie_core_sva
bind mie_core mie_core_sva chk_u (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i),
	.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .irq_mask_i(irq_mask_i), .periph_i(periph_i),
	.periph_pend_o(periph_pend_o), .irq_req_o(irq_req_o));

/* testbench/testbench.sv */
`timescale 1ns/1ps
module testbench;
	import mie_pkg::*;
	logic sys_clk_i, srst_i, reg_wr_i, reg_rd_i, irq_mask_i, irq_ack_i, awu_halt_i, wake_o;
	logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, a, sh_a, sh_b;
	logic [3:0] irq_ack_num_i;
	logic [4:0] ext_line_i, periph_pend_o, fire, en, clr;
	logic [31:0] seed, d;
	mie_pwr_t pwr_mode_i;
	mie_periph_t periph_i;
	mie_req_t irq_req_o;
	int error_cnt, n_compared, c, b;
	mie_src_model src_u (.sys_clk_i(sys_clk_i), .fire_i(fire), .en_i(en), .clr_i(clr), .periph_o(periph_i));
	mie_core dut_u (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .irq_mask_i(irq_mask_i),
		.irq_ack_i(irq_ack_i), .irq_ack_num_i(irq_ack_num_i), .pwr_mode_i(pwr_mode_i),
		.awu_halt_i(awu_halt_i), .irq_req_o(irq_req_o), .wake_o(wake_o), .ext_line_i(ext_line_i),
		.periph_i(periph_i), .periph_pend_o(periph_pend_o));
	initial begin
		sys_clk_i = 1'b0;
		forever #25 sys_clk_i = ~sys_clk_i;
	end
	task automatic tick(input int k);
		repeat (k) @(posedge sys_clk_i);
	endtask : tick
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
		reg_addr_i <= ad;
		reg_wdata_i <= dt;
		reg_wr_i <= 1'b1;
		tick(1);
		reg_wr_i <= 1'b0;
		tick(1);
	endtask : wr
	task automatic rd(input logic [7:0] ad, input logic [7:0] exp);
		reg_addr_i <= ad;
		reg_rd_i <= 1'b1;
		tick(1);
		reg_rd_i <= 1'b0;
		#1 chk(16'(reg_rdata_o), 16'(exp));
		tick(1);
	endtask : rd
	task automatic ack(input int n);
		irq_ack_i <= 1'b1;
		irq_ack_num_i <= 4'(n);
		tick(1);
		irq_ack_i <= 1'b0;
		tick(2);
	endtask : ack
	task automatic src(input logic [4:0] f, input logic [4:0] cl);
		fire <= f;
		clr <= cl;
		tick(1);
		fire <= 5'h00;
		clr <= 5'h00;
		tick(4);
	endtask : src
	function automatic logic [7:0] exp_sense(input logic [7:0] ad, input logic [7:0] dt);
		return ad == SENSE_A_OFS ? dt & SENSE_A_MASK : dt & SENSE_B_MASK;
	endfunction : exp_sense
	// Mode index m: 0 active-halt, 1 halt, 2 wait
	function automatic logic exp_wake(input int bit_n, input int m);
		return m == 2 || (bit_n == 0 ? m == 1 : (m == 0 && (bit_n == 2 || bit_n == 4)));
	endfunction : exp_wake
	function automatic logic exp_ext_wake(input int k, input int m, input logic fell);
		return m == 2 || (k == 4 ? m == 0 : !(k == 2 && fell));
	endfunction : exp_ext_wake
	function automatic mie_pwr_t mode_of(input int m);
		return m == 0 ? MIE_ACTIVE_HALT : (m == 1 ? MIE_HALT : MIE_WAIT);
	endfunction : mode_of
	task automatic summarize;
		$display("compared %0d, mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : summarize
	initial begin
		tick(5000);
		error_cnt++;
		summarize();
	end
	initial begin
		{error_cnt, n_compared} = 0;
		seed = 32'ha8d27ca4;
		{sh_a, sh_b} = {SENSE_A_RST, SENSE_B_RST};
		{srst_i, irq_mask_i, awu_halt_i} = 3'b110;
		{reg_wr_i, reg_rd_i, irq_ack_i, reg_addr_i, reg_wdata_i, irq_ack_num_i} = '0;
		{fire, clr, en} = '0;
		ext_line_i = 5'h1F;
		pwr_mode_i = MIE_RUN;
		tick(3);
		srst_i <= 1'b0;
		tick(1);
		rd(SENSE_A_OFS, SENSE_A_RST);
		rd(SENSE_B_OFS, SENSE_B_RST);
		rd(8'h50, 8'h00);
		for (c = 0; c < 24; c++) begin
			d = $random(seed);
			a = d[8] ? SENSE_B_OFS : SENSE_A_OFS;
			irq_mask_i <= d[9] | (c < 2);
			wr(a, d[7:0]);
			if (d[9] | (c < 2)) begin
				if (d[8]) sh_b = exp_sense(a, d[7:0]);
				else sh_a = exp_sense(a, d[7:0]);
				rd(a, exp_sense(a, d[7:0]));
			end else rd(a, d[8] ? sh_b : sh_a);
		end
		for (c = 0; c < 4; c++) begin
			irq_mask_i <= 1'b1;
			wr(SENSE_A_OFS, 8'(c));
			irq_mask_i <= 1'b0;
			ext_line_i[0] <= 1'b0;
			tick(3);
			chk(16'(irq_req_o.valid), 16'(c != 1));
			if (c != 1) chk(irq_req_o.vector, 16'hFFF8);
			ack(SRC_EXT0);
			if (c != 0) chk(16'(irq_req_o.valid), 16'h0);
			ext_line_i[0] <= 1'b1;
			tick(3);
			if (c != 0) chk(16'(irq_req_o.valid), 16'(c % 2));
			ack(SRC_EXT0);
		end
		irq_mask_i <= 1'b1;
		wr(SENSE_A_OFS, 8'(SENSE_FALL));
		ext_line_i[0] <= 1'b0;
		tick(2);
		wr(SENSE_A_OFS, 8'(SENSE_BOTH));
		irq_mask_i <= 1'b0;
		tick(3);
		chk(16'(irq_req_o.valid), 16'h0);
		ext_line_i[0] <= 1'b1;
		tick(3);
		chk(16'(irq_req_o.valid), 16'h1);
		ack(SRC_EXT0);
		irq_mask_i <= 1'b1;
		en <= 5'h1F;
		src(5'h11, 5'h00);
		chk(16'(periph_pend_o), 16'h11);
		chk(16'(irq_req_o.valid), 16'h0);
		irq_mask_i <= 1'b0;
		tick(3);
		chk(irq_req_o.vector, 16'hFFFA);
		src(5'h00, 5'h01);
		chk(irq_req_o.vector, 16'hFFE4);
		en <= 5'h00;
		src(5'h00, 5'h10);
		en <= 5'h1F;
		tick(3);
		chk(16'(irq_req_o.valid), 16'h0);
		awu_halt_i <= 1'b1;
		for (b = 0; b < 15; b++) begin
			pwr_mode_i <= mode_of(b % 3);
			src(5'(1 << (b / 3)), 5'h00);
			chk(16'(wake_o), 16'(exp_wake(b / 3, b % 3)));
			pwr_mode_i <= MIE_RUN;
			src(5'h00, 5'(1 << (b / 3)));
		end
		// External lines on rising edges, then the third line on a falling edge
		irq_mask_i <= 1'b1;
		awu_halt_i <= 1'b0;
		wr(SENSE_A_OFS, 8'h15);
		wr(SENSE_B_OFS, 8'h05);
		irq_mask_i <= 1'b0;
		for (b = 0; b < 15; b++) begin
			c = b / 3;
			pwr_mode_i <= mode_of(b % 3);
			ext_line_i[c] <= 1'b0;
			tick(2);
			ext_line_i[c] <= 1'b1;
			tick(3);
			chk(16'(wake_o), 16'(exp_ext_wake(c, b % 3, 1'b0)));
			pwr_mode_i <= MIE_RUN;
			ack(c < 3 ? c + 1 : c + 2);
		end
		irq_mask_i <= 1'b1;
		wr(SENSE_A_OFS, 8'h20);
		irq_mask_i <= 1'b0;
		for (b = 0; b < 3; b++) begin
			pwr_mode_i <= mode_of(b);
			ext_line_i[2] <= 1'b0;
			tick(3);
			chk(16'(wake_o), 16'(exp_ext_wake(2, b, 1'b1)));
			pwr_mode_i <= MIE_RUN;
			ext_line_i[2] <= 1'b1;
			ack(3);
		end
		// Reset in mid-run brings the settings back
		srst_i <= 1'b1;
		tick(2);
		srst_i <= 1'b0;
		tick(1);
		rd(SENSE_A_OFS, SENSE_A_RST);
		rd(SENSE_B_OFS, SENSE_B_RST);
		summarize();
	end
endmodule : testbench
